// File: logic/beat_fifo.sv
// Synchronous valid/ready FIFO parameterised in width and depth
`timescale 1ns/1ns
module beat_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wr;      // Write pointer
        logic [PW-1:0] rd;      // Read pointer
        logic [PW:0] cnt;       // Fill level
        logic ready;            // Registered not-full
    } fstate_t;

    fstate_t q, d;
    logic [WIDTH-1:0] mem [DEPTH];   // Storage words
    logic push;
    logic pop;

    // Pointer and level update; ready is registered so full is exact
    always_comb begin
        d = q;
        push = in_valid && q.ready;
        pop = (q.cnt != '0) && out_ready;
        if (push) begin
            d.wr = (q.wr == PW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = (q.rd == PW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
        end
        d.cnt = q.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        d.ready = (d.cnt != DEPTH_CNT);
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '{wr: '0, rd: '0, cnt: '0, ready: 1'b1};
        end else begin
            q <= d;
        end
    end

    // Storage write has no reset; contents are don't-care until pushed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[q.wr] <= in_data;
        end
    end

    assign in_ready = q.ready;
    assign out_valid = (q.cnt != '0);
    assign out_data = mem[q.rd];
endmodule : beat_fifo

// File: logic/sdram_core.sv
// Command core of a four-bank synchronous DRAM: refresh, masks, suspend, precharge
//
// Contract
// [R1] Auto refresh on RAS, CAS low, CKE, WE high
// [R2] Auto refresh restores row without external precharge
// [R3] Controller waits row cycle time after refresh
// [R4] Self refresh entry decoded with CKE low
// [R5] Self refresh ignores inputs; CKE high exits
// [R6] Controller waits row cycle after self refresh exit
// [R7] Read mask floats lane two clocks later
// [R8] Write mask blocks beat with zero latency
// [R9] Mask bit i governs byte lane i
// [R10] CKE low freezes burst, one clock latency
// [R11] Controller precharges all banks before power down
// [R12] Power down ignores all but clock, CKE
// [R13] Controller limits power down to refresh period
// [R14] CKE high leaves power down, one clock latency
// [R15] Read auto precharge before last output beat
// [R16] Write auto precharge after write recovery time
// [R17] RAS, WE low, CAS high means precharge
// [R18] Precharge with bit low closes selected bank
// [R19] Controller may precharge early during read burst
// [R20] Controller waits write recovery before precharge
// [R21] New access or precharge cuts a burst
// [R22] Burst stop ends burst, bank stays open
// [R23] Burst stop discards remaining write data
// [R24] Controller precharges all banks before any refresh
// [R25] Refresh addresses come from internal counter
// [R26] Precharge with bit high closes all banks
// [R27] Burst stop is RAS, CAS high, WE low
`timescale 1ns/1ns
module sdram_core
    import sdram_core_pkg::*;
#(
    parameter int CAS_LATENCY = 3,            // 2 or 3
    parameter int BURST_LEN = 4,              // 1, 2, 4 or 8
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [BA_W-1:0] ba,
    input wire logic [LANES-1:0] dqm,
    input wire logic [DQ_W-1:0] dq_i,
    output logic [DQ_W-1:0] dq_o,
    output logic [LANES-1:0] dq_oe,
    output logic [BANKS-1:0] bank_open,
    output logic [REF_CNT_W-1:0] refresh_addr,
    output logic self_refresh,
    output logic power_down,
    output logic write_ready
);
    localparam int CL_IDX = CAS_LATENCY - CL_MIN;     // Read pipe stage feeding the pins
    localparam logic [BURST_W-1:0] BL = BURST_W'(BURST_LEN);
    localparam logic [COL_W-1:0] BL_MASK = COL_W'(BURST_LEN - 1);
    localparam logic [WR_TMR_W-1:0] WR_CNT = WR_TMR_W'(WR_CYCLES);
    localparam logic [SREF_TMR_W-1:0] SREF_CNT = SREF_TMR_W'(SELF_REFRESH_CYCLES);

    // State of the core outside storage and the write FIFO
    typedef struct packed {
        pins_t s1;                              // First synchroniser stage
        pins_t s2;                              // Second stage, the sampled pins
        logic cke_q;                            // CKE one edge back: internal clock gate
        mode_t mode;                            // Operating mode
        logic [BANKS-1:0] open;                 // Banks with a row open
        logic [BANKS-1:0][MEM_ROW_W-1:0] row;   // Open row per bank
        logic busy;                             // Burst in progress
        logic wr;                               // Burst is a write
        logic ap;                               // Burst ends in auto precharge
        logic [BA_W-1:0] bank;                  // Bank of the burst
        logic [COL_W-1:0] col;                  // Next column of the burst
        logic [BURST_W-1:0] left;               // Beats still to go
        logic ap_rd;                            // Read auto precharge due next cycle
        logic [BA_W-1:0] ap_rd_bank;
        logic [WR_TMR_W-1:0] wr_tmr;            // Write recovery countdown, 0 = idle
        logic [BA_W-1:0] wr_bank;
        logic [CL_MAX-2:0] rd_vld;              // Read pipe valid bits
        logic [CL_MAX-2:0][DQ_W-1:0] rd_dat;    // Read pipe data
        logic [DQ_W-1:0] dq_out;
        logic [LANES-1:0] dq_en;
        logic [REF_CNT_W-1:0] ref_addr;         // Internal refresh row and bank
        logic [SREF_TMR_W-1:0] sref_tmr;        // Self refresh interval timer
        logic sref;                             // Self refresh flag for the status pin
        logic pdn;                              // Power down flag for the status pin
    } state_t;

    state_t q, d;
    pins_t pins_in;
    pins_t p;                    // Synchronised pins
    cmd_t cmd;                   // Decoded command
    logic run;                   // Internal clock running, commands honoured
    logic rd_issue;              // A read beat leaves storage this cycle
    logic [MEM_AW-1:0] rd_addr;
    logic [DQ_W-1:0] rd_word;
    logic [CL_MAX-1:0] vld_stage;
    logic [CL_MAX-1:0][DQ_W-1:0] dat_stage;
    logic [BANKS-1:0] pre_mask;  // Banks closed by an explicit precharge
    wbeat_t wbeat;               // Beat pushed toward storage
    logic wpush;
    wbeat_t drain;
    logic drain_valid;
    logic drain_ready;
    logic fifo_ready;
    logic [DQ_W-1:0] mem [2**MEM_AW];   // Storage model

    // Command decode; chip select masks everything but CKE and the masks
    function automatic cmd_t decode(input pins_t pn);
        cmd_t c;
        c = CMD_NOP;
        if (!pn.cs_n) begin
            case ({pn.ras_n, pn.cas_n, pn.we_n})
                3'b011: c = CMD_ACTIVATE;
                3'b101: c = CMD_READ;
                3'b100: c = CMD_WRITE;
                3'b010: c = CMD_PRECHARGE;                              // [R17]
                3'b001: c = pn.cke ? CMD_AUTO_REFRESH : CMD_SELF_REFRESH; // [R1] [R4]
                3'b110: c = CMD_BURST_STOP;                             // [R27]
                3'b000: c = CMD_MODE_SET;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction : decode

    // Storage index of a column in the open row of a bank
    function automatic logic [MEM_AW-1:0] mem_index(input logic [BA_W-1:0] b,
                                                    input logic [MEM_ROW_W-1:0] r,
                                                    input logic [COL_W-1:0] c);
        return {b, r, c};
    endfunction : mem_index

    // Next column, wrapping inside the burst boundary
    function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] c);
        return (c & ~BL_MASK) | ((c + 1'b1) & BL_MASK);
    endfunction : next_col

    assign pins_in = '{cke: cke, cs_n: cs_n, ras_n: ras_n, cas_n: cas_n, we_n: we_n,
                       addr: addr, ba: ba, dqm: dqm, dq: dq_i};
    assign p = q.s2;
    assign cmd = decode(p);
    assign rd_word = mem[rd_addr];

    // Next-state logic
    always_comb begin
        d = q;
        d.s1 = pins_in;
        d.s2 = q.s1;
        d.cke_q = q.s2.cke;
        run = (q.mode == MODE_ACTIVE) && q.cke_q;       // [R10] [R14]
        rd_issue = 1'b0;
        rd_addr = '0;
        wpush = 1'b0;
        wbeat = '0;
        pre_mask = '0;

        case (q.mode)
            // Commands are honoured when CKE was high one edge back
            MODE_ACTIVE: begin
                if (q.cke_q && !p.cke) begin
                    if (cmd == CMD_SELF_REFRESH) begin
                        d.mode = MODE_SELF_REFRESH;                     // [R4]
                        d.busy = 1'b0;
                        d.sref_tmr = SREF_CNT;
                    end else if (q.busy || (q.rd_vld != '0)) begin
                        d.mode = MODE_SUSPEND;                          // [R10]
                    end else begin
                        d.mode = MODE_POWER_DOWN;                       // [R14]
                    end
                end
            end
            // Burst frozen; CKE back high resumes one clock later
            MODE_SUSPEND: begin
                if (p.cke) begin
                    d.mode = MODE_ACTIVE;                               // [R10]
                end
            end
            // Only CKE is looked at
            MODE_POWER_DOWN: begin
                if (p.cke) begin
                    d.mode = MODE_ACTIVE;                               // [R12] [R14]
                end
            end
            // Internal timer refreshes; all inputs but CKE ignored
            MODE_SELF_REFRESH: begin
                if (q.sref_tmr == SREF_TMR_W'(1)) begin
                    d.sref_tmr = SREF_CNT;
                    d.ref_addr = q.ref_addr + 1'b1;                     // [R25]
                end else begin
                    d.sref_tmr = q.sref_tmr - 1'b1;
                end
                if (p.cke) begin
                    d.mode = MODE_SELF_REFRESH_EXIT;                    // [R5]
                end
            end
            // Exit takes effect on the second edge after CKE rises
            MODE_SELF_REFRESH_EXIT: begin
                d.mode = MODE_ACTIVE;                                   // [R5]
            end
            default: begin
                d.mode = MODE_ACTIVE;
            end
        endcase

        if (run) begin
            // Pending auto precharges close their bank
            if (q.ap_rd) begin
                d.open[q.ap_rd_bank] = 1'b0;                            // [R15]
                d.ap_rd = 1'b0;
            end
            if (q.wr_tmr != '0) begin
                d.wr_tmr = q.wr_tmr - 1'b1;
                if (q.wr_tmr == WR_TMR_W'(1)) begin
                    d.open[q.wr_bank] = 1'b0;                           // [R16]
                end
            end

            // Continue the running burst unless a command cuts it
            if (q.busy && !(cmd inside {CMD_READ, CMD_WRITE, CMD_BURST_STOP})) begin
                if (q.wr) begin
                    wpush = (p.dqm != '1);                              // [R8]
                    wbeat = '{addr: mem_index(q.bank, q.row[q.bank], q.col),
                              be: ~p.dqm, data: p.dq};                  // [R9]
                end else begin
                    rd_issue = 1'b1;
                    rd_addr = mem_index(q.bank, q.row[q.bank], q.col);
                end
                d.col = next_col(q.col);
                d.left = q.left - 1'b1;
                if (q.left == BURST_W'(1)) begin
                    d.busy = 1'b0;
                    if (q.ap && q.wr) begin
                        d.wr_tmr = WR_CNT;                              // [R16]
                        d.wr_bank = q.bank;
                    end else if (q.ap) begin
                        d.ap_rd = 1'b1;                                 // [R15]
                        d.ap_rd_bank = q.bank;
                    end
                end
            end

            case (cmd)
                CMD_ACTIVATE: begin
                    d.open[p.ba] = 1'b1;
                    d.row[p.ba] = p.addr[MEM_ROW_W-1:0];
                end
                // A new access restarts the burst engine
                CMD_READ, CMD_WRITE: begin
                    d.wr = (cmd == CMD_WRITE);                          // [R21]
                    d.ap = p.addr[AUTO_PRECHARGE_ADDRESS_BIT];
                    d.bank = p.ba;
                    d.col = next_col(p.addr[COL_W-1:0]);
                    d.left = BL - 1'b1;
                    d.busy = (BL != BURST_W'(1));
                    if (cmd == CMD_WRITE) begin
                        wpush = (p.dqm != '1);                          // [R8]
                        wbeat = '{addr: mem_index(p.ba, q.row[p.ba], p.addr[COL_W-1:0]),
                                  be: ~p.dqm, data: p.dq};              // [R9]
                    end else begin
                        rd_issue = 1'b1;
                        rd_addr = mem_index(p.ba, q.row[p.ba], p.addr[COL_W-1:0]);
                    end
                    if (BL == BURST_W'(1) && cmd == CMD_WRITE && d.ap) begin
                        d.wr_tmr = WR_CNT;                              // [R16]
                        d.wr_bank = p.ba;
                    end else if (BL == BURST_W'(1) && d.ap) begin
                        d.ap_rd = 1'b1;                                 // [R15]
                        d.ap_rd_bank = p.ba;
                    end
                end
                // One bank, or every bank when the select bit is high
                CMD_PRECHARGE: begin
                    if (p.addr[AUTO_PRECHARGE_ADDRESS_BIT]) begin
                        pre_mask = '1;                                  // [R26]
                    end else begin
                        pre_mask[p.ba] = 1'b1;                          // [R18]
                    end
                    d.open = d.open & ~pre_mask;
                    if (pre_mask[q.bank]) begin
                        d.busy = 1'b0;                                  // [R21]
                    end
                end
                // Beat of this cycle is dropped; bank left open
                CMD_BURST_STOP: begin
                    d.busy = 1'b0;                                      // [R22] [R23]
                end
                // Row restored internally, so no bank state changes
                CMD_AUTO_REFRESH: begin
                    d.ref_addr = q.ref_addr + 1'b1;                     // [R1] [R2] [R25]
                end
                default: begin
                end
            endcase

            // Read pipe and pin drivers; mask sampled now floats lane next edge
            vld_stage = {q.rd_vld, rd_issue};
            dat_stage = {q.rd_dat, rd_word};
            d.rd_vld = vld_stage[CL_MAX-2:0];
            d.rd_dat = dat_stage[CL_MAX-2:0];
            d.dq_out = dat_stage[CL_IDX];
            d.dq_en = {LANES{vld_stage[CL_IDX]}} & ~p.dqm;              // [R7] [R9]
        end else begin
            vld_stage = '0;
            dat_stage = '0;
            if (q.mode != MODE_SUSPEND) begin
                d.dq_en = '0;
            end
        end
        // Flags follow the next mode so the status pins leave a flop directly
        d.sref = (d.mode == MODE_SELF_REFRESH);
        d.pdn = (d.mode == MODE_POWER_DOWN);
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.mode <= MODE_ACTIVE;
        end else begin
            q <= d;
        end
    end

    // Write beats wait here; reads own the storage port, so draining stalls on them
    beat_fifo #(
        .WIDTH($bits(wbeat_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_wfifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(wpush),
        .in_ready(fifo_ready),
        .in_data(wbeat),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain)
    );

    assign drain_ready = !rd_issue;

    // Byte-lane storage write from the FIFO head
    always_ff @(posedge clk) begin
        if (drain_valid && drain_ready) begin
            for (int i = 0; i < LANES; i++) begin
                if (drain.be[i]) begin
                    mem[drain.addr][i*LANE_W +: LANE_W] <= drain.data[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    assign dq_o = q.dq_out;
    assign dq_oe = q.dq_en;
    assign bank_open = q.open;
    assign refresh_addr = q.ref_addr;
    assign self_refresh = q.sref;
    assign power_down = q.pdn;
    assign write_ready = fifo_ready;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    autoref_count_a: assert property (run && cmd == CMD_AUTO_REFRESH // [R1]
        |=> refresh_addr == $past(refresh_addr) + 1'b1)
        else $error("auto refresh did not advance the refresh counter");
    selfref_entry_a: assert property (run && !p.cke && cmd == CMD_SELF_REFRESH // [R4]
        |=> self_refresh)
        else $error("self refresh not entered");
    selfref_ignore_a: assert property (self_refresh && !p.cke // [R5]
        |=> $stable(bank_open) && (self_refresh || q.mode == MODE_SELF_REFRESH_EXIT))
        else $error("state changed during self refresh");
    read_mask_a: assert property (run && p.dqm[0] |=> !dq_oe[0]) // [R7]
        else $error("masked read lane still driven");
    write_mask_a: assert property (wpush |-> wbeat.be == ~p.dqm && p.dqm != '1) // [R8]
        else $error("write beat ignores mask");
    suspend_hold_a: assert property (q.mode == MODE_SUSPEND && !p.cke // [R10]
        |=> $stable(dq_o) && $stable(q.left) ##1 $stable(q.left))
        else $error("burst moved while suspended");
    pdown_hold_a: assert property (power_down && !p.cke // [R12]
        |=> power_down && $stable(bank_open))
        else $error("power down reacted to inputs");
    rd_autopre_a: assert property (run && q.ap_rd |=> !bank_open[$past(q.ap_rd_bank)]) // [R15]
        else $error("read auto precharge did not close bank");
    pre_all_a: assert property (run && cmd == CMD_PRECHARGE // [R26]
        && p.addr[AUTO_PRECHARGE_ADDRESS_BIT] |=> bank_open == '0)
        else $error("precharge all left a bank open");
    burst_stop_a: assert property (run && cmd == CMD_BURST_STOP && !q.ap_rd // [R22]
        && q.wr_tmr == '0 |=> !q.busy && bank_open == $past(bank_open))
        else $error("burst stop mishandled");
endmodule : sdram_core

// File: logic/sdram_core_pkg.sv
// Shared constants and carrier types for the synchronous DRAM command core
package sdram_core_pkg;

    // Pin and array geometry
    localparam int DQ_W = 32;                    // Data bus width
    localparam int ADDR_W = 11;                  // Address pins
    localparam int BA_W = 2;                     // Bank select pins
    localparam int BANKS = 4;                    // Number of banks
    localparam int LANES = 4;                    // Byte mask inputs
    localparam int LANE_W = 8;                   // Bits per byte lane
    localparam int COL_W = 8;                    // Column address bits
    localparam int AUTO_PRECHARGE_ADDRESS_BIT = 8;
    localparam int MEM_ROW_W = 2;                // Row bits kept by the storage model
    localparam int MEM_AW = BA_W + MEM_ROW_W + COL_W;
    localparam int BURST_W = 8;                  // Width of the beat counter

    // Latencies in clocks
    localparam int CL_MIN = 2;
    localparam int CL_MAX = 3;
    localparam int MASK_OUTPUT_DISABLE_LATENCY = 2;
    localparam int MASK_WRITE_LATENCY = 0;
    localparam int CLOCK_SUSPEND_LATENCY = 1;

    // Times and their cycle counts
    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_RECOVERY_NS = 10;
    localparam int WR_CYC_RAW = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYCLES = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;
    localparam int REFRESH_PERIOD_MS = 32;
    localparam int REFRESH_ROWS = 2048;
    localparam int SREF_RAW = (REFRESH_PERIOD_MS * 1000000) / (REFRESH_ROWS * CLK_PERIOD_NS);
    localparam int SELF_REFRESH_CYCLES = (SREF_RAW < 1) ? 1 : SREF_RAW;
    localparam int SREF_TMR_W = 12;
    localparam int WR_TMR_W = 4;
    localparam int REF_CNT_W = ADDR_W + BA_W;    // Row and bank refresh counter

    // All pins sampled at one edge
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [BA_W-1:0] ba;
        logic [LANES-1:0] dqm;
        logic [DQ_W-1:0] dq;
    } pins_t;

    // One write beat on its way to storage
    typedef struct packed {
        logic [MEM_AW-1:0] addr;
        logic [LANES-1:0] be;
        logic [DQ_W-1:0] data;
    } wbeat_t;

    typedef enum logic [3:0] {
        CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
        CMD_AUTO_REFRESH, CMD_SELF_REFRESH, CMD_BURST_STOP, CMD_MODE_SET
    } cmd_t;

    typedef enum logic [2:0] {
        MODE_ACTIVE, MODE_SUSPEND, MODE_POWER_DOWN, MODE_SELF_REFRESH, MODE_SELF_REFRESH_EXIT
    } mode_t;

endpackage : sdram_core_pkg

// File: verif/sdram_ctrl_model.sv
// Controller-side model that encodes commands onto the strobe pins
`timescale 1ns/1ns
module sdram_ctrl_model
    import sdram_core_pkg::*;
(
    input wire cmd_t cmd,
    output logic [3:0] pins
);
    // Pins are {cs_n, ras_n, cas_n, we_n}; idle deselects the part
    always_comb begin
        case (cmd)
            CMD_ACTIVATE: pins = 4'h3;
            CMD_READ: pins = 4'h5;
            CMD_WRITE: pins = 4'h4;
            CMD_PRECHARGE: pins = 4'h2;
            CMD_AUTO_REFRESH: pins = 4'h1;
            CMD_SELF_REFRESH: pins = 4'h1;
            CMD_BURST_STOP: pins = 4'h6;
            default: pins = 4'hf;
        endcase
    end
endmodule : sdram_ctrl_model

// File: verif/sdram_refresh_powerdown_precharge_bench.sv
// Self-checking bench for the DRAM command core
`timescale 1ns/1ns
module sdram_refresh_powerdown_precharge_bench
    import sdram_core_pkg::*;
();
    logic clk = 1'h0, rst_n = 1'h0, cke = 1'h0, sref, pdn, wrdy;
    cmd_t cm = CMD_NOP;
    logic [ADDR_W-1:0] addr = 11'h000;
    logic [BA_W-1:0] ba = 2'h0;
    logic [LANES-1:0] dqm = 4'h0, dq_oe, oe;
    logic [DQ_W-1:0] dq_i = 32'h0, dq_o, mk, wa [4], wb [4];
    logic [BANKS-1:0] bank_open;
    logic [REF_CNT_W-1:0] ref_a, r0;
    logic [3:0] pins;
    int err_total = 0, n_compared = 0, seed = 32'h37d1, cnt;
    always #5 clk = ~clk;
    sdram_ctrl_model ctl (.cmd(cm), .pins(pins));
    sdram_core dut (.clk(clk), .rst_n(rst_n), .cke(cke), .cs_n(pins[3]), .ras_n(pins[2]),
        .cas_n(pins[1]), .we_n(pins[0]), .addr(addr), .ba(ba), .dqm(dqm), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe(dq_oe), .bank_open(bank_open), .refresh_addr(ref_a),
        .self_refresh(sref), .power_down(pdn), .write_ready(wrdy));
    // Expected read word: masked lanes keep the older data
    function automatic logic [DQ_W-1:0] merge(input logic [DQ_W-1:0] o, n, input logic [3:0] m);
        for (int i = 0; i < LANES; i++)
            merge[i*LANE_W +: LANE_W] = m[i] ? o[i*LANE_W +: LANE_W] : n[i*LANE_W +: LANE_W];
    endfunction : merge
    task chk(input logic [DQ_W-1:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One command per falling edge; the core samples it at the next rising edge
    task cyc(input cmd_t c, input logic [ADDR_W-1:0] a, input logic [BA_W-1:0] b);
        @(negedge clk);
        cm = c;
        addr = a;
        ba = b;
    endtask : cyc
    task idle(input int n);
        repeat (n) cyc(CMD_NOP, 11'h000, 2'h0);
    endtask : idle
    // Full write burst; second pass masks lane 0 on beat 1
    task wr(input logic m);
        for (int k = 0; k < 4; k++) begin
            cyc(k == 0 ? CMD_WRITE : CMD_NOP, 11'h000, 2'h0);
            dq_i = m ? wb[k] : wa[k];
            dqm = (m && k == 1) ? 4'h1 : 4'h0;
        end
        cyc(CMD_NOP, 11'h000, 2'h0);
        dq_i = ~dq_i; // Released bus must not echo the last beat
        dqm = 4'h0;
    endtask : wr
    task close_out;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        close_out();
    end
    initial begin
        for (int k = 0; k < 4; k++) begin
            wa[k] = $random(seed);
            wb[k] = $random(seed);
        end
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'h1;
        cke = 1'h1;
        idle(3);
        cyc(CMD_ACTIVATE, 11'h000, 2'h0);
        idle(3);
        wr(1'h0);
        wr(1'h1);
        chk(wrdy, 1'h1);
        idle(10);
        cyc(CMD_READ, 11'h000, 2'h0);
        idle(3);
        dqm = 4'h8;
        idle(1);
        dqm = 4'h0;
        for (int k = 0; k < 4; k++) begin
            oe = (k == 2) ? 4'h7 : 4'hf;
            mk = {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
            chk(dq_oe, oe);
            chk(dq_o & mk, merge(wa[k], wb[k], k == 1 ? 4'h1 : 4'h0) & mk);
            idle(1);
        end
        $display("test masks done");
        cyc(CMD_READ, 11'h000, 2'h0);
        cyc(CMD_BURST_STOP, 11'h000, 2'h0);
        idle(5);
        chk(dq_oe, 4'h0);
        chk(bank_open, 4'h1);
        cyc(CMD_READ, 11'h000, 2'h0);
        idle(2);
        cnt = 0;
        // Two clocks of low enable must stretch the burst by exactly two beats
        for (int i = 0; i < 12; i++) begin
            if (dq_oe === 4'hf) cnt++;
            if (i == 0) cke = 1'h0;
            if (i == 2) cke = 1'h1;
            idle(1);
        end
        chk(cnt, 6);
        $display("test suspend done");
        cyc(CMD_ACTIVATE, 11'h000, 2'h1);
        idle(1);
        cyc(CMD_PRECHARGE, 11'h000, 2'h0); // No burst in flight, writes long done
        idle(4);
        chk(bank_open, 4'h2);
        // Auto precharge closes bank 3 one edge after its last internal beat
        for (int k = 0; k < 2; k++) begin
            cyc(CMD_ACTIVATE, 11'h000, 2'h3);
            idle(2);
            cyc(k == 0 ? CMD_READ : CMD_WRITE, 11'h100, 2'h3);
            idle(6);
            chk(bank_open, 4'ha);
            idle(1);
            chk(bank_open, 4'h2);
        end
        cyc(CMD_ACTIVATE, 11'h000, 2'h2);
        idle(1);
        cyc(CMD_PRECHARGE, 11'h100, 2'h0);
        idle(4);
        chk(bank_open, 4'h0);
        idle(2); // All banks closed and precharge time spent
        r0 = ref_a;
        cyc(CMD_AUTO_REFRESH, 11'h000, 2'h0);
        idle(4);
        chk(ref_a, r0 + 13'h1);
        chk(bank_open, 4'h0);
        idle(7); // Row cycle time before the next command
        $display("test precharge refresh done");
        cyc(CMD_NOP, 11'h000, 2'h0);
        cke = 1'h0;
        idle(4);
        chk(pdn, 1'h1);
        cyc(CMD_READ, 11'h000, 2'h0); // Short stay, far inside the refresh period
        cke = 1'h1;
        idle(4);
        chk(pdn, 1'h0);
        chk(dq_oe, 4'h0);
        cyc(CMD_SELF_REFRESH, 11'h000, 2'h0);
        cke = 1'h0;
        idle(4);
        chk(sref, 1'h1);
        cke = 1'h1;
        idle(6);
        chk(sref, 1'h0);
        idle(7); // Row cycle time after the exit
        $display("test low power done");
        close_out();
    end
endmodule : sdram_refresh_powerdown_precharge_bench
